// ### pscs_gen.sv
// Compare-driven waveform generator with ADC sync, faults and interrupts.
// Assumes clock ticks, fault and sync-error pins are asynchronous levels.
`timescale 1ns/1ps

module pscs_gen
   import pscs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ce_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Clock ticks and pins from outside
   input  wire logic        pll_tick_in,
   input  wire logic        io_tick_in,
   input  wire logic        fault_a_in,
   input  wire logic        fault_b_in,
   input  wire logic        sync_err_in,
   // Waveform, sync and interrupt
   output logic             waveform_output_a_out,
   output logic             waveform_output_b_out,
   output logic             adc_sync_out,
   output logic             irq_out
);
   import pscs_pkg::*;

   // Two-flop synchronisers plus one edge stage for five pins
   logic [4:0] sy1_r, sy2_r, sy3_r;
   logic [4:0] pin_vec;
   logic [4:0] rise;

   // Registers and their next values
   logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;       // Module control register
   logic [STAT_W-1:0] stat_r, stat_nxt;       // Sticky status
   logic [STAT_W-1:0] mask_r, mask_nxt;       // Interrupt mask
   logic [7:0]        temp_r, temp_nxt;       // Shared temp high byte
   logic [11:0]       cmp_r   [4];            // Compare values
   logic [11:0]       cmp_nxt [4];
   logic [11:0]       cnt_r, cnt_nxt;         // Module counter
   logic              down_r, down_nxt;       // Counting down
   logic [5:0]        pre_r, pre_nxt;         // Prescaler
   logic [31:0]       rdat_r, rdat_nxt;       // Latched read data
   logic              err_r, err_nxt;         // Latched slave error
   logic              wa_r, wa_nxt;           // Output A
   logic              wb_r, wb_nxt;           // Output B
   logic              sync_r, sync_nxt;       // ADC sync pulse
   pscs_state_t       st_r, st_nxt;           // Run state

   // Decoded helpers
   logic       setup, access, wr, rd;
   logic       tick, src, at_top, at_zero, reload;
   logic       fault_ev, fault_stop, halt_ev;
   logic       m_ra, m_rb, m_sa, m_sb;
   logic [5:0] pre_lim;
   logic [2:0] fmode;
   logic       center;
   logic [1:0]  cmp_widx;   // Compare picked by the bus address
   logic [11:0] cmp_load;   // Temp high nibble joined to low byte

   // Map an address onto a compare byte register
   function automatic logic cmp_hit(input logic [7:0] a);
      cmp_hit = (a >= OFF_CMP_LO) && (a <= OFF_CMP_HI) && (a[1:0] == 2'h0);
   endfunction

   // Compare index from address, high byte at even word
   function automatic logic [1:0] cmp_idx(input logic [7:0] a);
      logic [7:0] d;
      d       = a - OFF_CMP_LO;
      cmp_idx = d[4:3];
   endfunction

   // Pin synchronisers; only stage two reads stage one
   assign pin_vec = {sync_err_in, fault_b_in, fault_a_in,
                     io_tick_in, pll_tick_in};
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sy1_r <= 5'h00;
         sy2_r <= 5'h00;
         sy3_r <= 5'h00;
      end else if (ce_in) begin
         sy1_r <= pin_vec;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
      end
   end
   assign rise = sy2_r & ~sy3_r;

   // Bus phases; one cycle setup, answer in first access cycle
   assign setup      = psel_in & ~penable_in;
   assign access     = psel_in & penable_in & ce_in;
   assign wr         = access & pwrite_in & ~err_r;
   assign rd         = access & ~pwrite_in & ~err_r;
   assign pready_out = psel_in & penable_in & ce_in;
   assign prdata_out = rdat_r;
   assign pslverr_out = err_r & pready_out;

   // Field views
   assign fmode  = ctrl_r[CTRL_FMODE +: 3];
   assign center = ctrl_r[CTRL_CENTER];
   assign cmp_widx = cmp_idx(paddr_in);
   assign cmp_load = {temp_r[3:0], pwdata_in[7:0]};

   // Source tick and prescaler terminal count
   always_comb begin
      src = ctrl_r[CTRL_CLKSEL] ? rise[0] : rise[1];
      case (ctrl_r[CTRL_DIV +: 2])
         2'h0:    pre_lim = PRE_LIM0;
         2'h1:    pre_lim = PRE_LIM1;
         2'h2:    pre_lim = PRE_LIM2;
         default: pre_lim = PRE_LIM3;
      endcase
   end
   assign tick = src && (pre_r == pre_lim) && (st_r == PSCS_RUN);

   // Compare matches on every count
   assign m_sa = (cnt_r == cmp_r[CMP_SA]);
   assign m_ra = (cnt_r == cmp_r[CMP_RA]);
   assign m_sb = (cnt_r == cmp_r[CMP_SB]);
   assign m_rb = (cnt_r == cmp_r[CMP_RB]);
   assign at_top  = (cnt_r >= cmp_r[CMP_RB]);
   assign at_zero = (cnt_r == 12'h000);
   // Reload closes on-time 1: wrap in ramp, floor in centered
   assign reload = tick & (center ? (down_r & at_zero) : at_top);

   // Fault handling
   assign fault_ev   = (rise[2] | rise[3]) & (st_r == PSCS_RUN);
   // Mode 7 takes either input against both phase pairs
   assign fault_stop = (fmode == FMODE_EITHER) ? (rise[2] | rise[3])
                                               : rise[2];
   assign halt_ev = (fmode[2:1] == FMODE_HALT) & fault_stop
                    & (st_r == PSCS_RUN);

   // Next-state logic for registers, counter, outputs
   always_comb begin
      ctrl_nxt = ctrl_r;
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      temp_nxt = temp_r;
      cmp_nxt  = cmp_r;
      cnt_nxt  = cnt_r;
      down_nxt = down_r;
      pre_nxt  = pre_r;
      rdat_nxt = rdat_r;
      err_nxt  = err_r;
      st_nxt   = st_r;
      wa_nxt   = wa_r;
      wb_nxt   = wb_r;
      sync_nxt = 1'b0;

      // Setup cycle: decode and latch read data
      if (setup) begin
         err_nxt  = 1'b0;
         rdat_nxt = 32'h0000_0000;
         if (paddr_in == OFF_CTRL) begin
            rdat_nxt[CTRL_W-1:0] = ctrl_r;
         end else if (paddr_in == OFF_STATUS) begin
            rdat_nxt[STAT_W-1:0] = stat_r;
         end else if (paddr_in == OFF_MASK) begin
            rdat_nxt[STAT_W-1:0] = mask_r;
         end else if (paddr_in == OFF_COUNT) begin
            rdat_nxt[11:0] = cnt_r;
         end else if (cmp_hit(paddr_in)) begin
            if (paddr_in[2]) begin
               rdat_nxt[7:0] = cmp_r[cmp_idx(paddr_in)][7:0];
            end else begin
               rdat_nxt[3:0] = cmp_r[cmp_idx(paddr_in)][11:8];
            end
         end else begin
            err_nxt = 1'b1; // Unmapped address
         end
      end

      // Register writes at the access edge
      if (wr) begin
         if (paddr_in == OFF_CTRL) begin
            ctrl_nxt = pwdata_in[CTRL_W-1:0];
         end else if (paddr_in == OFF_MASK) begin
            mask_nxt = pwdata_in[STAT_W-1:0];
         end else if (cmp_hit(paddr_in)) begin
            if (!paddr_in[2]) begin
               temp_nxt = pwdata_in[7:0];
            end else begin
               // Low byte moves temp and low together
               cmp_nxt[cmp_widx] = cmp_load;
            end
         end
      end
      // Read clears only bits it reported; later events survive
      if (rd && paddr_in == OFF_STATUS) begin
         stat_nxt = stat_r & ~rdat_r[STAT_W-1:0];
      end

      // Run state machine
      case (st_r)
         PSCS_IDLE: begin
            if (ctrl_r[CTRL_RUN]) begin
               st_nxt = PSCS_RUN;
            end
         end
         PSCS_RUN: begin
            if (halt_ev) begin
               st_nxt = PSCS_HALT;
               ctrl_nxt[CTRL_RUN] = 1'b0;
            end else if (!ctrl_r[CTRL_RUN]) begin
               st_nxt = PSCS_IDLE;
            end
         end
         PSCS_HALT: begin
            // Stays halted until software sets run again
            if (ctrl_r[CTRL_RUN]) begin
               st_nxt = PSCS_RUN;
            end
         end
         default: st_nxt = PSCS_IDLE;
      endcase

      // Prescaler on the selected source tick
      if (st_r != PSCS_RUN) begin
         pre_nxt = 6'h00;
      end else if (src) begin
         pre_nxt = (pre_r >= pre_lim) ? 6'h00 : pre_r + 6'h01;
      end

      // Counter: ramp wraps at end B, centered turns at end B and zero
      if (st_r != PSCS_RUN) begin
         cnt_nxt  = 12'h000;
         down_nxt = 1'b0;
      end else if (tick) begin
         if (center) begin
            if (!down_r && at_top) begin
               down_nxt = 1'b1;
               cnt_nxt  = cnt_r - 12'h001;
            end else if (down_r && at_zero) begin
               down_nxt = 1'b0;
               cnt_nxt  = cnt_r + 12'h001;
            end else if (down_r) begin
               cnt_nxt = cnt_r - 12'h001;
            end else begin
               cnt_nxt = cnt_r + 12'h001;
            end
         end else begin
            down_nxt = 1'b0;
            cnt_nxt  = at_top ? 12'h000 : cnt_r + 12'h001;
         end
      end

      // Waveforms: ramp sets at start, clears at end match; centered compares count with start
      if (st_nxt != PSCS_RUN) begin
         wa_nxt = 1'b0;
         wb_nxt = 1'b0;
      end else if (center) begin
         // End A takes no part here, only sync
         wa_nxt = (cnt_nxt < cmp_r[CMP_SA]);
         wb_nxt = (cnt_nxt >= cmp_r[CMP_SB]);
      end else if (tick) begin
         if (m_sa) wa_nxt = 1'b1;
         if (m_ra) wa_nxt = 1'b0;
         if (m_sb) wb_nxt = 1'b1;
         if (m_rb) wb_nxt = 1'b0;
      end

      // ADC sync pulse, one cycle
      if (center) begin
         case (ctrl_r[CTRL_SYNC +: 2])
            2'h0:    sync_nxt = tick & m_ra & down_r;
            2'h1:    sync_nxt = tick & m_ra & ~down_r;
            default: sync_nxt = 1'b0;
         endcase
      end else begin
         case (ctrl_r[CTRL_SYNC +: 2])
            2'h0:    sync_nxt = wa_nxt & ~wa_r;
            2'h1:    sync_nxt = ~wa_nxt & wa_r;
            2'h2:    sync_nxt = wb_nxt & ~wb_r;
            default: sync_nxt = ~wb_nxt & wb_r;
         endcase
      end

      // Events set sticky bits, winning over a clear
      if (reload)                     stat_nxt[ST_RELOAD]  = 1'b1;
      if (fault_ev)                   stat_nxt[ST_FAULT]   = 1'b1;
      if (rise[4])                    stat_nxt[ST_SYNCERR] = 1'b1;
      if (tick && !center && m_ra)    stat_nxt[ST_CMPA]    = 1'b1;
      if (tick && m_rb)               stat_nxt[ST_CMPB]    = 1'b1;
   end

   // Register update, frozen while enable is low
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_r <= CTRL_RST;
         stat_r <= '0;
         mask_r <= MASK_RST;
         temp_r <= 8'h00;
         for (int i = 0; i < 4; i++) cmp_r[i] <= CMP_RST;
         cnt_r  <= 12'h000;
         down_r <= 1'b0;
         pre_r  <= 6'h00;
         rdat_r <= 32'h0000_0000;
         err_r  <= 1'b0;
         st_r   <= PSCS_IDLE;
         wa_r   <= 1'b0;
         wb_r   <= 1'b0;
         sync_r <= 1'b0;
      end else if (ce_in) begin
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         temp_r <= temp_nxt;
         cmp_r  <= cmp_nxt;
         cnt_r  <= cnt_nxt;
         down_r <= down_nxt;
         pre_r  <= pre_nxt;
         rdat_r <= rdat_nxt;
         err_r  <= err_nxt;
         st_r   <= st_nxt;
         wa_r   <= wa_nxt;
         wb_r   <= wb_nxt;
         sync_r <= sync_nxt;
      end
   end

   // Outputs from flip-flops, interrupt from masked status
   assign waveform_output_a_out = wa_r;
   assign waveform_output_b_out = wb_r;
   assign adc_sync_out          = sync_r;
   assign irq_out               = |(stat_r & mask_r);

   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   property p_halt;
      halt_ev && ce_in |=> st_r == PSCS_HALT && !ctrl_r[CTRL_RUN];
   endproperty
   a_halt: assert property (p_halt) else $error("halt missed");

   property p_halt_hold;
      st_r == PSCS_HALT && !ctrl_r[CTRL_RUN] && ce_in
         |=> st_r == PSCS_HALT;
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("left halt alone");

   property p_mode7;
      st_r == PSCS_RUN && fmode == FMODE_EITHER && rise[3] && ce_in
         |=> !wa_r && !wb_r;
   endproperty
   a_mode7: assert property (p_mode7) else $error("b input ignored");

   property p_sync_none;
      center && ctrl_r[CTRL_SYNC + 1] && ce_in |=> !sync_r;
   endproperty
   a_sync_none: assert property (p_sync_none)
      else $error("sync in off code");

   sequence s_rise_a;
      !wa_r ##1 wa_r;
   endsequence
   property p_sync_rise;
      s_rise_a ##0 (!center && ctrl_r[CTRL_SYNC +: 2] == 2'h0
         && $stable(ctrl_r)) |-> sync_r;
   endproperty
   a_sync_rise: assert property (p_sync_rise)
      else $error("no sync on a rise");

   property p_irq;
      irq_out == |(stat_r & mask_r);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_reload;
      reload && ce_in |=> stat_r[ST_RELOAD];
   endproperty
   a_reload: assert property (p_reload) else $error("reload lost");

   property p_low_byte;
      wr && cmp_hit(paddr_in) && paddr_in[2]
         |=> cmp_r[$past(cmp_widx)] == $past(cmp_load);
   endproperty
   a_low_byte: assert property (p_low_byte)
      else $error("compare not loaded");

   property p_high_only;
      wr && cmp_hit(paddr_in) && !paddr_in[2]
         |=> $stable(cmp_r[CMP_RA]) && $stable(cmp_r[CMP_RB]);
   endproperty
   a_high_only: assert property (p_high_only)
      else $error("high byte wrote compare");

endmodule // pscs_gen

// ### pscs_pkg.sv
// Constants, register map and types for the compare/sync generator slice.
// Assumes a single 125 MHz clock and an APB master with 32-bit data.
package pscs_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00; // Module control register
   localparam logic [7:0] OFF_STATUS = 8'h04; // Sticky events, read clears
   localparam logic [7:0] OFF_MASK   = 8'h08; // Interrupt mask
   localparam logic [7:0] OFF_COUNT  = 8'h0C; // Counter value, read only
   localparam logic [7:0] OFF_CMP_LO = 8'h10; // First compare byte register
   localparam logic [7:0] OFF_CMP_HI = 8'h2C; // Last compare byte register
   // Compare order: start A, end A, start B, end B; high byte then low
   localparam int CMP_SA = 0;
   localparam int CMP_RA = 1;
   localparam int CMP_SB = 2;
   localparam int CMP_RB = 3;
   // Control field positions
   localparam int CTRL_RUN    = 0; // Run request bit
   localparam int CTRL_CLKSEL = 1; // Clock source select, 1 = PLL tick
   localparam int CTRL_DIV    = 2; // Clock divide select, 2 bits
   localparam int CTRL_SYNC   = 4; // Sync select low/high, 2 bits
   localparam int CTRL_FMODE  = 6; // Fault mode, 3 bits
   localparam int CTRL_CENTER = 9; // Center-aligned counting
   localparam int CTRL_W      = 10;
   // Status and mask bit positions
   localparam int ST_RELOAD  = 0; // Counter reload, end of on-time 1
   localparam int ST_FAULT   = 1; // Fault input event
   localparam int ST_SYNCERR = 2; // Mutual synchronisation error
   localparam int ST_CMPA    = 3; // Compare end A match
   localparam int ST_CMPB    = 4; // Compare end B match
   localparam int STAT_W     = 5;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [STAT_W-1:0] MASK_RST = 5'h00;
   localparam logic [11:0]       CMP_RST  = 12'h000;
   // Fault mode codes
   localparam logic [2:0] FMODE_EITHER = 3'h7; // Either input, both pairs
   localparam logic [1:0] FMODE_HALT   = 2'h3; // Upper bits of 11x
   // Prescaler terminal counts for divide codes 0..3 (1, 4, 16, 64)
   localparam logic [5:0] PRE_LIM0 = 6'h00;
   localparam logic [5:0] PRE_LIM1 = 6'h03;
   localparam logic [5:0] PRE_LIM2 = 6'h0F;
   localparam logic [5:0] PRE_LIM3 = 6'h3F;
   // Run state, one-hot
   typedef enum logic [2:0] {
      PSCS_IDLE = 3'b001,
      PSCS_RUN  = 3'b010,
      PSCS_HALT = 3'b100
   } pscs_state_t;
endpackage

// ### pscs_stage_model.sv
// Far-side model: power stage fault pins and ADC sample-and-hold.
// Assumes callers start its task just after a rising clock edge.
`timescale 1ns/1ps
module pscs_stage_model (
   // Clock
   input  wire logic        mclk_in,
   // Generator outputs
   input  wire logic        wave_a_in,
   input  wire logic        wave_b_in,
   input  wire logic        adc_sync_in,
   // Fault and error lines to the generator
   output logic             fault_a_out,
   output logic             fault_b_out,
   output logic             sync_err_out,
   // Sample count and output levels at the last sample
   output logic      [15:0] samples_out,
   output logic      [1:0]  last_ab_out
);
   // Lines idle low, nothing sampled yet
   initial begin
      fault_a_out = 1'b0;
      fault_b_out = 1'b0;
      sync_err_out = 1'b0;
      samples_out = 16'h0000;
      last_ab_out = 2'h0;
   end

   // Sample and hold fires once per sync pulse
   always @(posedge mclk_in) begin
      if (adc_sync_in === 1'b1) begin
         samples_out <= samples_out + 16'h0001;
         last_ab_out <= {wave_a_in, wave_b_in};
      end
   end

   // Pulse one line for four cycles: 0 fault A, 1 fault B, 2 sync error
   task automatic trip(input int which);
      fault_a_out <= (which == 0);
      fault_b_out <= (which == 1);
      sync_err_out <= (which == 2);
      repeat (4) @(posedge mclk_in);
      fault_a_out <= 1'b0;
      fault_b_out <= 1'b0;
      sync_err_out <= 1'b0;
      repeat (4) @(posedge mclk_in);
   endtask
endmodule // pscs_stage_model

// ### tb.sv
// Self-checking bench for the compare/sync generator slice.
// Assumes zero-wait APB answers and ticks driven from this bench.
`timescale 1ns/1ps
module tb;
   import pscs_pkg::*;
   logic        mclk_in;            // 125 MHz clock
   logic        rst_n_in;           // Sync reset, active low
   logic        ce;                 // Clock enable
   logic        psel, penable;      // APB control
   logic        pwrite, pready, pslverr;
   logic [7:0]  paddr;              // APB byte address
   logic [31:0] pwdata, prdata, rd; // Write, read, last read data
   logic        rd_err;             // Error of last transfer
   logic        pll_tick, io_tick;  // Clock source ticks
   logic        fault_a, fault_b, sync_err;
   logic        wave_a, wave_b, adc_sync, irq;
   logic [15:0] samples;            // ADC samples taken
   logic [1:0]  last_ab;            // Output levels at last sample
   int          fail_count = 0;
   int          num_checks = 0;
   int          cyc = 0;

   // Clock
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end

   pscs_gen u_pscs_gen (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .pll_tick_in(pll_tick), .io_tick_in(io_tick),
      .fault_a_in(fault_a), .fault_b_in(fault_b),
      .sync_err_in(sync_err), .waveform_output_a_out(wave_a),
      .waveform_output_b_out(wave_b), .adc_sync_out(adc_sync),
      .irq_out(irq));

   pscs_stage_model u_pscs_stage_model (
      .mclk_in(mclk_in), .wave_a_in(wave_a), .wave_b_in(wave_b),
      .adc_sync_in(adc_sync), .fault_a_out(fault_a),
      .fault_b_out(fault_b), .sync_err_out(sync_err),
      .samples_out(samples), .last_ab_out(last_ab));

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   // Compare one value
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask

   // One APB transfer; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_in);
      penable <= 1'b1;
      do begin
         @(posedge mclk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_in);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   // Compare byte address
   function automatic logic [7:0] ca(input int idx, input int lo);
      return 8'(OFF_CMP_LO + 8 * idx + 4 * lo);
   endfunction

   // High byte first, low byte commits both
   task automatic set_cmp(input int idx, input logic [11:0] v);
      wr(ca(idx, 0), {28'h0000000, v[11:8]});
      wr(ca(idx, 1), {24'h000000, v[7:0]});
   endtask

   // Source ticks, six cycles apart, then settle
   task automatic ticks(input logic pll, input int n);
      repeat (n) begin
         pll_tick <= pll;
         io_tick <= ~pll;
         repeat (3) @(posedge mclk_in);
         pll_tick <= 1'b0;
         io_tick <= 1'b0;
         repeat (3) @(posedge mclk_in);
      end
      repeat (6) @(posedge mclk_in);
   endtask

   // Reset values and unmapped access
   task automatic s_reset_regs();
      rd_chk("ctrl", OFF_CTRL, 32'(CTRL_RST));
      rd_chk("mask", OFF_MASK, 32'(MASK_RST));
      rd_chk("ra hi", ca(CMP_RA, 0), 32'(CMP_RST));
      rd_chk("rb lo", ca(CMP_RB, 1), 32'(CMP_RST));
      apb(1'b0, 8'h30, 32'h0);
      chk("slverr", 32'h1, 32'(rd_err));
      chk("irq", 32'h0, 32'(irq));
   endtask

   // Shared high-byte holding register
   task automatic s_temp_byte();
      wr(ca(CMP_RA, 0), 32'h5);
      rd_chk("ra hi held", ca(CMP_RA, 0), 32'h0);
      wr(ca(CMP_SB, 0), 32'hA);
      wr(ca(CMP_RA, 1), 32'h34);
      rd_chk("ra hi", ca(CMP_RA, 0), 32'hA);
      rd_chk("ra lo", ca(CMP_RA, 1), 32'h34);
   endtask

   // Source select and prescaler
   task automatic s_clock_src();
      set_cmp(CMP_RB, 12'h009);
      wr(OFF_CTRL, 32'h5);
      ticks(1'b1, 8);
      rd_chk("cnt other src", OFF_COUNT, 32'h0);
      ticks(1'b0, 8);
      rd_chk("cnt div4", OFF_COUNT, 32'h2);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'hB);
      ticks(1'b1, 16);
      rd_chk("cnt div16", OFF_COUNT, 32'h1);
      ce <= 1'b0;
      ticks(1'b1, 16);
      ce <= 1'b1;
      rd_chk("cnt frozen", OFF_COUNT, 32'h1);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'hF);
      ticks(1'b1, 64);
      rd_chk("cnt div64", OFF_COUNT, 32'h1);
      wr(OFF_CTRL, 32'h0);
   endtask

   // Ramp sync sources, compare flags and interrupt
   task automatic s_ramp_sync();
      logic [1:0]  ab [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
      logic [15:0] s0;
      set_cmp(CMP_SA, 12'h002);
      set_cmp(CMP_RA, 12'h005);
      set_cmp(CMP_SB, 12'h003);
      apb(1'b0, OFF_STATUS, 32'h0);
      for (int c = 0; c < 4; c++) begin
         s0 = samples;
         wr(OFF_CTRL, 32'(1 + 16 * c));
         ticks(1'b0, 20);
         chk("ramp syncs", 32'h2, 32'(samples - s0));
         chk("sync levels", 32'(ab[c]), 32'(last_ab));
         wr(OFF_CTRL, 32'h0);
      end
      wr(OFF_MASK, 32'h2);
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFF_MASK, 32'h1);
      chk("irq set", 32'h1, 32'(irq));
      rd_chk("status", OFF_STATUS, 32'h19);
      chk("irq clear", 32'h0, 32'(irq));
      rd_chk("status clr", OFF_STATUS, 32'h0);
   endtask

   // Centered sync codes: down, up, none, none
   task automatic s_center_sync();
      int          e9 [4] = '{0, 1, 0, 0};
      int          e18 [4] = '{1, 1, 0, 0};
      logic [15:0] s0;
      set_cmp(CMP_RA, 12'h003);
      for (int c = 0; c < 4; c++) begin
         s0 = samples;
         wr(OFF_CTRL, 32'(513 + 16 * c));
         ticks(1'b0, 9);
         chk("ctr up", 32'(e9[c]), 32'(samples - s0));
         ticks(1'b0, 9);
         chk("ctr period", 32'(e18[c]), 32'(samples - s0));
         wr(OFF_CTRL, 32'h0);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
   endtask

   // Halt on fault, wait for software, either input in mode 7
   task automatic s_fault();
      wr(OFF_CTRL, 32'h181);
      ticks(1'b0, 3);
      chk("run out", 32'h2, 32'({wave_a, wave_b}));
      u_pscs_stage_model.trip(0);
      rd_chk("halt ctrl", OFF_CTRL, 32'h180);
      chk("halt out", 32'h0, 32'({wave_a, wave_b}));
      ticks(1'b0, 3);
      rd_chk("halt cnt", OFF_COUNT, 32'h0);
      rd_chk("fault st", OFF_STATUS, 32'h2);
      wr(OFF_CTRL, 32'h181);
      ticks(1'b0, 2);
      rd_chk("resume cnt", OFF_COUNT, 32'h2);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h1C1);
      ticks(1'b0, 1);
      u_pscs_stage_model.trip(2);
      u_pscs_stage_model.trip(1);
      rd_chk("halt b", OFF_CTRL, 32'h1C0);
      rd_chk("err st", OFF_STATUS, 32'h6);
   endtask

   // Main sequence
   initial begin
      rst_n_in = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pll_tick = 1'b0;
      io_tick = 1'b0;
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      s_reset_regs();
      s_temp_byte();
      s_clock_src();
      s_ramp_sync();
      s_center_sync();
      s_fault();
      end_sim();
   end
endmodule // tb
